// *** verilog/ppm_pin_mux.sv ***
// module: port a and b pin function mux top level

// Overview of operation
// [RQ1] analog channel routed only when direction and analog select both set
// [RQ2] a4, a7, b0 open drain: no pull-up, no high drive, change detect kept
// [RQ3] i2c mode puts scl on port a pin 7
// [RQ4] i2c mode puts sda on port b pin 0
// [RQ5] multi-phase: b1 is shared current, master drives, slave receives
// [RQ6] sync modes: b3 is switching clock, master drives, slave receives
// [RQ7] a3 and b3 selectable as timer gate sources one and two; the code takes source two from b2, not b3
// [RQ8] a5 input only with pull-up, change detect, master clear for programming
// [RQ9] a6 cmos io; programming data on small part, capture input on large
// [RQ10] mode bit keeps supply regulator on or off during sleep
// [RQ11] adc defaults to internal analog supply reference
// [RQ12] large part: b7 selectable as external adc reference
// [RQ13] large part: b4, b5 are programming and debug data and clock
// [RQ14] port direction registers set pin direction, one per port
// [RQ15] a3 has weak current source instead of pull-up
// [RQ16] three bit field selects standalone, multi-output or multi-phase roles
// [RQ17] sync modes: a1 is switching sync signal, master drives
// [RQ18] analog selected pins read zero on the data path
module ppm_pin_mux (
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       large_variant_i,
	input  wire logic       dir_a_we_i,
	input  wire logic       dir_b_we_i,
	input  wire logic       ana_a_we_i,
	input  wire logic       ana_b_we_i,
	input  wire logic       lat_a_we_i,
	input  wire logic       lat_b_we_i,
	input  wire logic       mode_we_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [7:0] pullup_en_i,
	input  wire logic       i2c_en_i,
	input  wire logic       prog_mode_i,
	input  wire logic       ext_ref_sel_i,
	input  wire logic       sleep_i,
	input  wire logic [7:0] pad_a_i,
	input  wire logic [7:0] pad_b_i,
	input  wire logic       scl_drive_low_i,
	input  wire logic       sda_drive_low_i,
	input  wire logic       sync_out_i,
	input  wire logic       sw_clk_out_i,
	input  wire logic       shared_cur_out_i,
	input  wire logic       prog_data_out_i,
	input  wire logic       prog_data_oe_i,
	output logic      [7:0] pad_a_o,
	output logic      [7:0] pad_a_oe_o,
	output logic      [7:0] pad_b_o,
	output logic      [7:0] pad_b_oe_o,
	output logic      [7:0] pullup_a_o,
	output logic      [7:0] pullup_b_o,
	output logic      [7:0] current_src_a_o,
	output logic      [7:0] port_a_data_o,
	output logic      [7:0] port_b_data_o,
	output logic      [7:0] port_a_direction_reg_o,
	output logic      [7:0] port_b_direction_reg_o,
	output logic      [7:0] mode_configuration_reg_o,
	output logic      [7:0] adc_chan_valid_o,
	output logic            adc_ref_sel_o,
	output logic            scl_in_o,
	output logic            sda_in_o,
	output logic            sync_in_o,
	output logic            sw_clk_in_o,
	output logic            shared_cur_in_o,
	output logic            timer_gate_source_one_o,
	output logic            timer_gate_source_two_o,
	output logic            master_clear_input_o,
	output logic            program_data_line_o,
	output logic            program_clock_line_o,
	output logic            debug_data_line_o,
	output logic            debug_clock_line_o,
	output logic            capture_compare_input_one_o,
	output logic            capture_compare_input_two_o,
	output logic            regulator_en_o,
	output logic      [7:0] change_a_o,
	output logic      [7:0] change_b_o
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] dir_a_ff;
	logic [7:0] dir_b_ff;
	logic [7:0] ana_a_ff;
	logic [7:0] ana_b_ff;
	logic [7:0] lat_a_ff;
	logic [7:0] lat_b_ff;
	logic [7:0] prev_a_ff;
	logic [7:0] prev_b_ff;
	logic       armed_ff;
	logic [7:0] in_a;
	logic [7:0] in_b;
	logic [7:0] od_a_mask;
	logic [7:0] pu_a_mask;
	logic [7:0] cs_a_mask;
	logic       sync_mode;
	logic       master;
	logic       phase_mode;
	logic       mux_scl;
	logic       mux_sda;
	logic       mux_sync;
	logic       mux_swclk;
	logic       mux_cur;
	logic       small_prog;
	logic       large_prog;

	ppm_mode_if mode_bus ();

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dir_a_ff <= ppm_pkg::RST_DIR;
			dir_b_ff <= ppm_pkg::RST_DIR;
			ana_a_ff <= ppm_pkg::RST_ANALOG;
			ana_b_ff <= ppm_pkg::RST_ANALOG;
			lat_a_ff <= ppm_pkg::RST_ANALOG;
			lat_b_ff <= ppm_pkg::RST_ANALOG;
		end else begin
			if (dir_a_we_i) dir_a_ff <= wdata_i; // [RQ14]
			if (dir_b_we_i) dir_b_ff <= wdata_i; // [RQ14]
			if (ana_a_we_i) ana_a_ff <= wdata_i;
			if (ana_b_we_i) ana_b_ff <= wdata_i;
			if (lat_a_we_i) lat_a_ff <= wdata_i;
			if (lat_b_we_i) lat_b_ff <= wdata_i;
		end
	end

	// ----------------------------------------
	// submodules
	// ----------------------------------------
	ppm_mode_dec u_mode (
		.core_clk_i               (core_clk_i),
		.resetn_i                 (resetn_i),
		.mode_we_i                (mode_we_i),
		.mode_wdata_i             (wdata_i),
		.mode_configuration_reg_o (mode_configuration_reg_o),
		.mode                     (mode_bus)
	);

	ppm_adc_sel u_adc (
		.dir_a_i         (dir_a_ff),
		.ana_a_i         (ana_a_ff),
		.dir_b_i         (dir_b_ff),
		.ana_b_i         (ana_b_ff),
		.large_variant_i (large_variant_i),
		.ext_ref_sel_i   (ext_ref_sel_i),
		.chan_valid_o    (adc_chan_valid_o),
		.adc_ref_sel_o   (adc_ref_sel_o)
	);

	assign sync_mode  = mode_bus.sync_en;
	assign master     = mode_bus.is_master;
	assign phase_mode = mode_bus.phase_en;

	// ----------------------------------------
	// pin function selection
	// ----------------------------------------
	assign mux_scl    = i2c_en_i; // [RQ3]
	assign mux_sda    = i2c_en_i; // [RQ4]
	assign mux_sync   = sync_mode; // [RQ17]
	assign mux_swclk  = sync_mode; // [RQ6]
	assign mux_cur    = phase_mode; // [RQ5]
	assign small_prog = prog_mode_i & ~large_variant_i; // [RQ9]
	assign large_prog = prog_mode_i & large_variant_i; // [RQ13]

	// open drain pins a4, a7; b0 handled below
	assign od_a_mask = 8'h90; // [RQ2]
	// pull-ups: not on open drain, not on a2/a3 current source pins
	assign pu_a_mask = 8'h63; // [RQ2] [RQ8] [RQ15]
	assign cs_a_mask = 8'h0C; // [RQ15]

	assign pullup_a_o      = pullup_en_i & pu_a_mask & dir_a_ff;
	assign pullup_b_o      = pullup_en_i & 8'hFE & dir_b_ff; // [RQ2]
	assign current_src_a_o = pullup_en_i & cs_a_mask & dir_a_ff; // [RQ15]

	// ----------------------------------------
	// port a drive
	// ----------------------------------------
	always_comb begin
		pad_a_o    = lat_a_ff & ~od_a_mask;
		pad_a_oe_o = ~dir_a_ff & ~ana_a_ff & ~od_a_mask;
		// open drain: only pull low
		pad_a_oe_o[4] = ~dir_a_ff[4] & ~lat_a_ff[4]; // [RQ2]
		pad_a_oe_o[7] = ~dir_a_ff[7] & ~lat_a_ff[7]; // [RQ2]
		pad_a_oe_o[5] = 1'b0; // [RQ8]
		if (mux_sync) begin
			pad_a_o[1]    = sync_out_i; // [RQ17]
			pad_a_oe_o[1] = master; // [RQ17]
		end
		if (small_prog) begin
			pad_a_o[6]    = prog_data_out_i; // [RQ9]
			pad_a_oe_o[6] = prog_data_oe_i; // [RQ9]
			pad_a_oe_o[7] = 1'b0;
		end else if (mux_scl) begin
			pad_a_oe_o[7] = scl_drive_low_i; // [RQ3]
		end
	end

	// ----------------------------------------
	// port b drive
	// ----------------------------------------
	always_comb begin
		pad_b_o    = lat_b_ff & 8'hFE;
		pad_b_oe_o = ~dir_b_ff & ~ana_b_ff & 8'hFE;
		pad_b_oe_o[0] = mux_sda ? sda_drive_low_i : (~dir_b_ff[0] & ~lat_b_ff[0]); // [RQ2] [RQ4]
		if (!large_variant_i) begin
			pad_b_oe_o[7:4] = 4'h0;
		end
		if (mux_cur) begin
			pad_b_o[1]    = shared_cur_out_i; // [RQ5]
			pad_b_oe_o[1] = master; // [RQ5]
		end
		if (mux_swclk) begin
			pad_b_o[3]    = sw_clk_out_i; // [RQ6]
			pad_b_oe_o[3] = master; // [RQ6]
		end
		if (large_prog) begin
			pad_b_o[4]    = prog_data_out_i; // [RQ13]
			pad_b_oe_o[4] = prog_data_oe_i; // [RQ13]
			pad_b_oe_o[5] = 1'b0; // [RQ13]
		end
		if (adc_ref_sel_o == ppm_pkg::REF_EXTERNAL) begin
			pad_b_oe_o[7] = 1'b0; // [RQ12]
		end
	end

	// ----------------------------------------
	// input path
	// ----------------------------------------
	assign in_a = pad_a_i & ~ana_a_ff; // [RQ18]
	assign in_b = pad_b_i & ~ana_b_ff; // [RQ18]
	assign port_a_data_o = in_a;
	assign port_b_data_o = large_variant_i ? in_b : {4'h0, in_b[3:0]};

	assign scl_in_o        = mux_scl & pad_a_i[7]; // [RQ3]
	assign sda_in_o        = mux_sda & pad_b_i[0]; // [RQ4]
	assign sync_in_o       = mux_sync & ~master & pad_a_i[1]; // [RQ17]
	assign sw_clk_in_o     = mux_swclk & ~master & pad_b_i[3]; // [RQ6]
	assign shared_cur_in_o = mux_cur & ~master & pad_b_i[1]; // [RQ5]
	assign timer_gate_source_one_o = in_a[3]; // [RQ7]
	assign timer_gate_source_two_o = in_b[2]; // [RQ7]
	assign master_clear_input_o    = prog_mode_i & pad_a_i[5]; // [RQ8]
	assign program_data_line_o  = large_prog ? pad_b_i[4] : (small_prog & pad_a_i[6]); // [RQ9] [RQ13]
	assign program_clock_line_o = large_prog ? pad_b_i[5] : (small_prog & pad_a_i[7]); // [RQ13]
	assign debug_data_line_o    = large_variant_i & pad_b_i[4]; // [RQ13]
	assign debug_clock_line_o   = large_variant_i & pad_b_i[5]; // [RQ13]
	assign capture_compare_input_one_o = large_variant_i & in_a[6]; // [RQ9]
	assign capture_compare_input_two_o = large_variant_i & in_b[6];
	// regulator stays on unless sleeping with keep bit clear
	assign regulator_en_o = ~sleep_i | mode_bus.sleep_keep; // [RQ10]

	// ----------------------------------------
	// interrupt-on-change detection
	// ----------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_a_ff <= ppm_pkg::RST_ANALOG;
			prev_b_ff <= ppm_pkg::RST_ANALOG;
			armed_ff  <= 1'b0;
		end else begin
			prev_a_ff <= in_a;
			prev_b_ff <= in_b;
			armed_ff  <= 1'b1;
		end
	end
	// no change reported before a first sample after reset, so no false edge
	assign change_a_o = armed_ff ? (prev_a_ff ^ in_a) : 8'h00; // [RQ2] [RQ8] [RQ15]
	assign change_b_o = armed_ff ? (prev_b_ff ^ in_b) : 8'h00; // [RQ2]

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_adc_gate;
		@(posedge core_clk_i) disable iff (!resetn_i)
		adc_chan_valid_o[ppm_pkg::CH_A3] == (dir_a_ff[3] & ana_a_ff[3]);
	endproperty
	a_adc_gate: assert property (p_adc_gate) else $error("adc channel 3 gating wrong"); // [RQ1]

	property p_od_a;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!pad_a_o[4] && !pullup_a_o[4] && !pullup_a_o[7] && !pullup_b_o[0];
	endproperty
	a_od_a: assert property (p_od_a) else $error("open drain pin drives high or pulls up"); // [RQ2]

	property p_scl;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(i2c_en_i && !prog_mode_i) |-> (pad_a_oe_o[7] == scl_drive_low_i);
	endproperty
	a_scl: assert property (p_scl) else $error("scl not on port a pin 7"); // [RQ3]

	property p_sda;
		@(posedge core_clk_i) disable iff (!resetn_i)
		i2c_en_i |-> (pad_b_oe_o[0] == sda_drive_low_i && sda_in_o == pad_b_i[0]);
	endproperty
	a_sda: assert property (p_sda) else $error("sda not on port b pin 0"); // [RQ4]

	property p_cur;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(phase_mode && master) |-> (pad_b_oe_o[1] && pad_b_o[1] == shared_cur_out_i);
	endproperty
	a_cur: assert property (p_cur) else $error("master not driving shared current"); // [RQ5]

	property p_swclk;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(sync_mode && !master) |-> (!pad_b_oe_o[3] && sw_clk_in_o == pad_b_i[3]);
	endproperty
	a_swclk: assert property (p_swclk) else $error("slave switching clock wrong"); // [RQ6]

	property p_a5_input;
		@(posedge core_clk_i) disable iff (!resetn_i)
		!pad_a_oe_o[5];
	endproperty
	a_a5_input: assert property (p_a5_input) else $error("input only pin driven"); // [RQ8]

	property p_reg;
		@(posedge core_clk_i) disable iff (!resetn_i)
		(sleep_i && !mode_configuration_reg_o[ppm_pkg::SLEEP_KEEP_BIT]) |-> !regulator_en_o;
	endproperty
	a_reg: assert property (p_reg) else $error("regulator on in sleep with keep clear"); // [RQ10]

	property p_dir;
		@(posedge core_clk_i) disable iff (!resetn_i)
		dir_b_we_i |=> (port_b_direction_reg_o == $past(wdata_i));
	endproperty
	a_dir: assert property (p_dir) else $error("port b direction write lost"); // [RQ14]

	property p_ana_zero;
		@(posedge core_clk_i) disable iff (!resetn_i)
		ana_a_ff[3] |-> !port_a_data_o[3];
	endproperty
	a_ana_zero: assert property (p_ana_zero) else $error("analog pin reads nonzero"); // [RQ18]

	assign port_a_direction_reg_o = dir_a_ff;
	assign port_b_direction_reg_o = dir_b_ff;
endmodule : ppm_pin_mux

// *** verilog/ppm_pkg.sv ***
// package: constants for the port pin function mux
package ppm_pkg;
	// system configuration field encodings
	localparam logic [2:0] SYS_STANDALONE   = 3'h0;
	localparam logic [2:0] SYS_MULTI_OUT_MS = 3'h1;
	localparam logic [2:0] SYS_MULTI_OUT_SL = 3'h2;
	localparam logic [2:0] SYS_PHASE_MS     = 3'h3;
	localparam logic [2:0] SYS_PHASE_SL     = 3'h4;
	// field positions
	localparam int unsigned SYSCFG_LSB      = 0;
	localparam int unsigned SYSCFG_MSB      = 2;
	localparam int unsigned SLEEP_KEEP_BIT  = 3;
	// analog channel numbers of port pins
	localparam logic [2:0] CH_A3            = 3'h3;
	localparam logic [2:0] CH_B1            = 3'h4;
	localparam logic [2:0] CH_B4            = 3'h6;
	localparam logic [2:0] CH_B5            = 3'h7;
	// reset values
	localparam logic [7:0] RST_DIR          = 8'hFF;
	localparam logic [7:0] RST_ANALOG       = 8'h00;
	localparam logic [7:0] RST_MODE         = 8'h00;
	// adc reference selection
	localparam logic       REF_INTERNAL     = 1'b0;
	localparam logic       REF_EXTERNAL     = 1'b1;
endpackage : ppm_pkg

// *** verilog/ppm_mode_if.sv ***
// interface: decoded system mode between decoder and mux
interface ppm_mode_if;
	logic sync_en;
	logic is_master;
	logic phase_en;
	logic sleep_keep;
	modport dec (output sync_en, output is_master, output phase_en, output sleep_keep);
	modport mux (input sync_en, input is_master, input phase_en, input sleep_keep);
endinterface : ppm_mode_if

// *** verilog/ppm_mode_dec.sv ***
// module: mode configuration register and decode
module ppm_mode_dec (
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	input  wire logic       mode_we_i,
	input  wire logic [7:0] mode_wdata_i,
	output logic      [7:0] mode_configuration_reg_o,
	ppm_mode_if.dec         mode
);
	logic [7:0] mode_ff;
	logic [2:0] sel;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_ff <= ppm_pkg::RST_MODE;
		end else if (mode_we_i) begin
			mode_ff <= mode_wdata_i;
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign sel = mode_ff[ppm_pkg::SYSCFG_MSB:ppm_pkg::SYSCFG_LSB]; // [RQ16]
	assign mode.sync_en    = (sel == ppm_pkg::SYS_MULTI_OUT_MS) || (sel == ppm_pkg::SYS_MULTI_OUT_SL)
		|| (sel == ppm_pkg::SYS_PHASE_MS) || (sel == ppm_pkg::SYS_PHASE_SL); // [RQ16]
	assign mode.is_master  = (sel == ppm_pkg::SYS_MULTI_OUT_MS) || (sel == ppm_pkg::SYS_PHASE_MS);
	assign mode.phase_en   = (sel == ppm_pkg::SYS_PHASE_MS) || (sel == ppm_pkg::SYS_PHASE_SL);
	assign mode.sleep_keep = mode_ff[ppm_pkg::SLEEP_KEEP_BIT]; // [RQ10]
	assign mode_configuration_reg_o = mode_ff;
endmodule : ppm_mode_dec

// *** verilog/ppm_adc_sel.sv ***
// module: analog channel gating and reference selection
module ppm_adc_sel (
	input  wire logic [7:0] dir_a_i,
	input  wire logic [7:0] ana_a_i,
	input  wire logic [7:0] dir_b_i,
	input  wire logic [7:0] ana_b_i,
	input  wire logic       large_variant_i,
	input  wire logic       ext_ref_sel_i,
	output logic      [7:0] chan_valid_o,
	output logic            adc_ref_sel_o
);
	logic [7:0] pin_ok;
	// channel n valid when direction and analog select set and, for channels 6 and 7, the part is large
	assign pin_ok[0] = dir_a_i[0] & ana_a_i[0];
	assign pin_ok[1] = dir_a_i[1] & ana_a_i[1];
	assign pin_ok[2] = dir_a_i[2] & ana_a_i[2];
	assign pin_ok[3] = dir_a_i[3] & ana_a_i[3]; // [RQ1]
	assign pin_ok[4] = dir_b_i[1] & ana_b_i[1];
	assign pin_ok[5] = dir_b_i[2] & ana_b_i[2];
	assign pin_ok[6] = dir_b_i[4] & ana_b_i[4] & large_variant_i; // [RQ13]
	assign pin_ok[7] = dir_b_i[5] & ana_b_i[5] & large_variant_i; // [RQ13]
	assign chan_valid_o = pin_ok; // [RQ1]
	// internal supply reference unless external selected on large part
	assign adc_ref_sel_o = (ext_ref_sel_i & large_variant_i) ? ppm_pkg::REF_EXTERNAL
		: ppm_pkg::REF_INTERNAL; // [RQ11] [RQ12]
endmodule : ppm_adc_sel

// *** verif/ppm_board_model.sv ***
// board model: external drivers, board pull-ups and floating lines at both ports
module ppm_board_model #(
	parameter logic [7:0] BOARD_PULL_A = 8'h90,
	parameter logic [7:0] BOARD_PULL_B = 8'h01
) (
	input  wire logic       core_clk_i,
	input  wire logic [7:0] out_a_i,
	input  wire logic [7:0] oe_a_i,
	input  wire logic [7:0] weak_a_i,
	input  wire logic [7:0] out_b_i,
	input  wire logic [7:0] oe_b_i,
	input  wire logic [7:0] weak_b_i,
	input  wire logic [7:0] ext_en_a_i,
	input  wire logic [7:0] ext_val_a_i,
	input  wire logic [7:0] ext_en_b_i,
	input  wire logic [7:0] ext_val_b_i,
	output logic      [7:0] level_a_o,
	output logic      [7:0] level_b_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// line resolution
	// ----------------------------------------
	logic [7:0] float_ff = 8'h55;
	// undriven, unpulled lines change every cycle
	always @(posedge core_clk_i) begin
		float_ff <= ~float_ff;
	end
	function automatic logic [7:0] resolve(input logic [7:0] o, e, en, v, pl, fl);
		return (e & o) | (~e & en & v) | (~e & ~en & pl) | (~e & ~en & ~pl & fl);
	endfunction : resolve
	// open-drain lines only rise through board resistors or enabled external drivers
	assign level_a_o = resolve(out_a_i, oe_a_i, ext_en_a_i, ext_val_a_i, weak_a_i | BOARD_PULL_A, float_ff);
	assign level_b_o = resolve(out_b_i, oe_b_i, ext_en_b_i, ext_val_b_i, weak_b_i | BOARD_PULL_B, ~float_ff);
endmodule : ppm_board_model

// *** verif/tb_port_pin_function_mux.sv ***
// testbench: self-checking bench for the port pin function mux
module tb_port_pin_function_mux;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic       core_clk_i = 1'b0, resetn_i = 1'b0, large_variant_i = 1'b0, i2c_en_i = 1'b0, prog_mode_i = 1'b0;
	logic       ext_ref_sel_i = 1'b0, sleep_i = 1'b0, scl_drive_low_i = 1'b0, sda_drive_low_i = 1'b0;
	logic       sync_out_i = 1'b0, sw_clk_out_i = 1'b0, shared_cur_out_i = 1'b0, prog_data_out_i = 1'b0;
	logic       prog_data_oe_i = 1'b0;
	logic [6:0] we = 7'h00;
	logic [7:0] wdata_i = 8'h00, pullup_en_i = 8'h00, pad_a_i, pad_b_i, seen_a, seen_b;
	logic [7:0] ext_en_a = 8'h00, ext_a = 8'h00, ext_en_b = 8'h00, ext_b = 8'h00;
	logic [7:0] pad_a_o, pad_a_oe_o, pad_b_o, pad_b_oe_o, pullup_a_o, pullup_b_o, current_src_a_o, port_a_data_o;
	logic [7:0] port_b_data_o, port_a_direction_reg_o, port_b_direction_reg_o, mode_configuration_reg_o;
	logic [7:0] adc_chan_valid_o, change_a_o, change_b_o;
	logic       adc_ref_sel_o, scl_in_o, sda_in_o, sync_in_o, sw_clk_in_o, shared_cur_in_o, regulator_en_o;
	logic       timer_gate_source_one_o, timer_gate_source_two_o, master_clear_input_o, program_data_line_o;
	logic       program_clock_line_o, debug_data_line_o, debug_clock_line_o;
	logic       capture_compare_input_one_o, capture_compare_input_two_o;
	// bench copies: dir a, dir b, analog a, analog b, latch a, latch b, mode
	logic [7:0] sh [7] = '{ppm_pkg::RST_DIR, ppm_pkg::RST_DIR, ppm_pkg::RST_ANALOG, ppm_pkg::RST_ANALOG,
		8'h00, 8'h00, ppm_pkg::RST_MODE};
	logic [7:0] msk [7] = '{8'hFF, 8'hFF, 8'h0D, 8'h04, 8'hFF, 8'hFF, 8'h0F};
	int         n_errors = 0;
	int         total_checks = 0;
	int unsigned seed_v;
	always #5 core_clk_i = ~core_clk_i;
	// ----------------------------------------
	// design and board
	// ----------------------------------------
	ppm_pin_mux u_ppm_pin_mux (
		.core_clk_i, .resetn_i, .large_variant_i, .dir_a_we_i(we[0]), .dir_b_we_i(we[1]), .ana_a_we_i(we[2]),
		.ana_b_we_i(we[3]), .lat_a_we_i(we[4]), .lat_b_we_i(we[5]), .mode_we_i(we[6]), .wdata_i, .pullup_en_i,
		.i2c_en_i, .prog_mode_i, .ext_ref_sel_i, .sleep_i, .pad_a_i, .pad_b_i, .scl_drive_low_i, .sda_drive_low_i,
		.sync_out_i, .sw_clk_out_i, .shared_cur_out_i, .prog_data_out_i, .prog_data_oe_i, .pad_a_o, .pad_a_oe_o,
		.pad_b_o, .pad_b_oe_o, .pullup_a_o, .pullup_b_o, .current_src_a_o, .port_a_data_o, .port_b_data_o,
		.port_a_direction_reg_o, .port_b_direction_reg_o, .mode_configuration_reg_o, .adc_chan_valid_o,
		.adc_ref_sel_o, .scl_in_o, .sda_in_o, .sync_in_o, .sw_clk_in_o, .shared_cur_in_o, .timer_gate_source_one_o,
		.timer_gate_source_two_o, .master_clear_input_o, .program_data_line_o, .program_clock_line_o,
		.debug_data_line_o, .debug_clock_line_o, .capture_compare_input_one_o, .capture_compare_input_two_o,
		.regulator_en_o, .change_a_o, .change_b_o
	);
	ppm_board_model u_ppm_board_model (
		.core_clk_i, .out_a_i(pad_a_o), .oe_a_i(pad_a_oe_o), .weak_a_i(pullup_a_o | current_src_a_o),
		.out_b_i(pad_b_o), .oe_b_i(pad_b_oe_o), .weak_b_i(pullup_b_o), .ext_en_a_i(ext_en_a), .ext_val_a_i(ext_a),
		.ext_en_b_i(ext_en_b), .ext_val_b_i(ext_b), .level_a_o(pad_a_i), .level_b_o(pad_b_i)
	);
	// ----------------------------------------
	// tasks and expectations
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic step();
		@(posedge core_clk_i);
		#1;
	endtask : step
	// one write pulse then an idle edge; entered just after a rising edge
	task automatic wr(input logic [6:0] sel, input logic [7:0] d);
		we = sel;
		wdata_i = d;
		step();
		we = 7'h00;
		for (int r = 0; r < 7; r++) begin
			if (sel[r]) sh[r] = d;
		end
		step();
	endtask : wr
	function automatic logic [7:0] exp_valid();
		return {{2{large_variant_i}} & sh[1][5:4] & sh[3][5:4], sh[1][2:1] & sh[3][2:1], sh[0][3:0] & sh[2][3:0]};
	endfunction : exp_valid
	task automatic chk_random();
		logic [2:0] md;
		logic sy, ms, ph;
		md = sh[6][2:0];
		sy = (md >= ppm_pkg::SYS_MULTI_OUT_MS) && (md <= ppm_pkg::SYS_PHASE_SL);
		ms = (md == ppm_pkg::SYS_MULTI_OUT_MS) || (md == ppm_pkg::SYS_PHASE_MS);
		ph = (md == ppm_pkg::SYS_PHASE_MS) || (md == ppm_pkg::SYS_PHASE_SL);
		check(adc_chan_valid_o, exp_valid());
		check(port_a_data_o, pad_a_i & ~sh[2]);
		check(port_b_data_o, pad_b_i & ~sh[3] & {{4{large_variant_i}}, 4'hF});
		check(port_a_direction_reg_o ^ port_b_direction_reg_o, sh[0] ^ sh[1]);
		check({pad_b_oe_o[2], pad_a_oe_o[3]}, {~sh[1][2] & ~sh[3][2], ~sh[0][3] & ~sh[2][3]});
		check({pad_a_o[7], pad_a_o[4], pad_b_o[0], pullup_a_o[7], pullup_a_o[4], pullup_b_o[0]}, 8'h00);
		check({pad_a_oe_o[7], pad_a_oe_o[4], pad_b_oe_o[0]},
			{~{sh[0][7], sh[0][4], sh[1][0]} & ~{sh[4][7], sh[4][4], sh[5][0]}});
		check(pad_a_oe_o[5], 1'b0);
		check({timer_gate_source_two_o, timer_gate_source_one_o},
			{pad_b_i[2] & ~sh[3][2], pad_a_i[3] & ~sh[2][3]});
		check(regulator_en_o, {~sleep_i | sh[6][ppm_pkg::SLEEP_KEEP_BIT]});
		check(adc_ref_sel_o, large_variant_i & ext_ref_sel_i);
		check(mode_configuration_reg_o, sh[6]);
		check({pad_a_oe_o[1], pad_b_oe_o[3], pad_b_oe_o[1]},
			{sy ? ms : ~sh[0][1], sy ? ms : ~sh[1][3], ph ? ms : ~sh[1][1]});
		if (sy && ms) check({pad_a_o[1], pad_b_o[3]}, {sync_out_i, sw_clk_out_i});
		if (sy && !ms) check({sync_in_o, sw_clk_in_o}, {pad_a_i[1], pad_b_i[3]});
		if (ph) check(ms ? pad_b_o[1] : shared_cur_in_o, ms ? shared_cur_out_i : pad_b_i[1]);
		if (!sy && !sh[0][1]) check(pad_a_o[1], sh[4][1]);
	endtask : chk_random
	task automatic results();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	// ----------------------------------------
	// watchdog and main sequence
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge core_clk_i);
		n_errors++;
		results();
	end
	initial begin
		seed_v = $urandom(60);
		repeat (16) @(posedge core_clk_i);
		#1;
		resetn_i = 1'b1;
		sleep_i = 1'b1;
		#4;
		check(port_a_direction_reg_o & port_b_direction_reg_o, ppm_pkg::RST_DIR);
		check({adc_ref_sel_o, regulator_en_o, mode_configuration_reg_o}, 10'h0);
		check({change_a_o, change_b_o}, 16'h0);
		step();
		wr(7'h03, 8'h0F);
		check({port_a_direction_reg_o, port_b_direction_reg_o}, 16'h0F0F);
		for (int i = 0; i < 40; i++) begin
			for (int r = 0; r < 7; r++) begin
				wr(7'(1 << r), 8'($urandom) & msk[r]);
			end
			{large_variant_i, sleep_i, ext_ref_sel_i, sync_out_i, sw_clk_out_i, shared_cur_out_i} = 6'($urandom);
			pullup_en_i = 8'($urandom);
			{ext_en_a, ext_a, ext_en_b, ext_b} = $urandom;
			#4;
			chk_random();
			step();
		end
		large_variant_i = 1'b1;
		{ext_en_a, ext_a, ext_en_b, ext_b} = 32'h0;
		i2c_en_i = 1'b1;
		pullup_en_i = 8'hFF;
		wr(7'h43, 8'hFF);
		wr(7'h4C, 8'h00);
		check({current_src_a_o, pullup_a_o & 8'hBF, pullup_b_o}, 24'h0C23FE);
		for (int k = 0; k < 4; k++) begin
			{sda_drive_low_i, scl_drive_low_i} = 2'(k);
			#4;
			check({pad_a_oe_o[7], pad_b_oe_o[0], pad_a_o[7], pad_b_o[0]}, {k[0], k[1], 2'b00});
			check({scl_in_o, sda_in_o}, {~k[0], ~k[1]});
			step();
		end
		ext_en_a = 8'hFF;
		ext_en_b = 8'hFF;
		#4;
		check({scl_in_o, sda_in_o}, 2'b00);
		step();
		i2c_en_i = 1'b0;
		repeat (2) step();
		#4;
		check({change_a_o, change_b_o}, 16'h0);
		step();
		ext_a = 8'hB8;
		ext_b = 8'h01;
		#4;
		{seen_a, seen_b} = {change_a_o, change_b_o};
		step();
		#4;
		check({seen_a | change_a_o, seen_b | change_b_o}, 16'hB801);
		step();
		{ext_a, ext_b} = 16'($urandom);
		#4;
		check({capture_compare_input_one_o, capture_compare_input_two_o}, {pad_a_i[6], pad_b_i[6]});
		step();
		prog_mode_i = 1'b1;
		#4;
		check({program_data_line_o, program_clock_line_o, debug_data_line_o, debug_clock_line_o},
			{2{pad_b_i[4], pad_b_i[5]}});
		step();
		large_variant_i = 1'b0;
		#4;
		check({program_data_line_o, program_clock_line_o, master_clear_input_o},
			{pad_a_i[6], pad_a_i[7], pad_a_i[5]});
		step();
		{prog_data_oe_i, prog_data_out_i} = 2'b11;
		#4;
		check({pad_a_oe_o[6], pad_a_o[6]}, 2'b11);
		step();
		{prog_mode_i, prog_data_oe_i, ext_ref_sel_i} = 3'b001;
		wr(7'h08, 8'h36);
		check(adc_chan_valid_o, exp_valid());
		large_variant_i = 1'b1;
		wr(7'h02, 8'h00);
		check({adc_chan_valid_o, adc_ref_sel_o, pad_b_oe_o[7]}, {exp_valid(), 2'b10});
		resetn_i = 1'b0;
		#4;
		check(port_a_direction_reg_o & port_b_direction_reg_o, ppm_pkg::RST_DIR);
		results();
	end
endmodule : tb_port_pin_function_mux
